// ===== inc/can_txq_pkg.sv
// Constants shared by the transmit queue and initialization control block
// Assumes a 32-bit AHB-Lite register bus and one module clock
package can_txq_pkg;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] CORE_CONTROL_OFS  = 8'h00;
	localparam logic [7:0] TX_ADD_REQ_OFS    = 8'h04;
	localparam logic [7:0] QUEUE_ADD_OFS     = 8'h08;
	localparam logic [7:0] TX_PENDING_OFS    = 8'h0c;
	localparam logic [7:0] INT_FLAGS_OFS     = 8'h10;
	localparam logic [7:0] INT_ENABLE_OFS    = 8'h14;
	localparam logic [7:0] ERROR_COUNTER_OFS = 8'h18;

	// ==========================================================
	// Field positions
	localparam int INIT_BIT       = 0;
	localparam int CSR_BIT        = 1;
	localparam int CSA_BIT        = 2;
	localparam int MSG_RAM_ACCESS_FAIL_FLAG_BIT       = 0;
	localparam int TXC_BIT        = 1;
	localparam int NUM_FLAGS      = 2;
	localparam int QFULL_BIT      = 8;
	localparam int EP_BIT         = 7;
	localparam int REC_WIDTH      = 7;

	// ==========================================================
	// Reset values and limits
	localparam logic                 INIT_RESET        = 1'b1;
	localparam logic [NUM_FLAGS-1:0] FLAGS_RESET       = 2'h0;
	localparam logic [NUM_FLAGS-1:0] ENABLE_RESET      = 2'h0;
	localparam logic [REC_WIDTH-1:0] REC_PASSIVE_LIMIT = 7'h7f;
	localparam logic [1:0]           HTRANS_NONSEQ     = 2'h2;
	localparam logic                 HRESP_OKAY        = 1'b0;

	// ==========================================================
	// Clock stop handshake states, Gray along the usual path
	typedef enum logic [1:0] {
		STOP_RUN     = 2'b00,
		STOP_WAIT    = 2'b01,
		STOP_STOPPED = 2'b11
	} stop_state_t;

endpackage

// ===== hdl/can_txq_ctrl.sv
// Transmit queue, group add request, clock stop handshake and RAM fail flag
// Assumes an AHB-Lite master and a protocol engine whose pins are asynchronous
//
// What this block does
// - Same-identifier queue buffers go out lowest buffer number first.
// - Each queue add write puts the lowest numbered free buffer into the queue.
// - One add-request write requests all selected buffers together; software avoids duplicates.
// - Init set during reception flags RAM access failure on next received frame.
// - Clock stop request makes device set init and acknowledge; request cleared first.
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps

module can_txq_ctrl #(
	parameter int NBUF = 8
) (
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic      [31:0]           hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	input  wire logic                  rx_active,
	input  wire logic                  rx_frame_done,
	input  wire logic                  error_passive_flag,
	input  wire logic [6:0]            rx_error_count,
	input  wire logic                  tx_done,
	output logic                       tx_req,
	output logic [$clog2(NBUF)-1:0]    tx_buf_sel,
	output logic                       init_active,
	output logic                       irq
);
	localparam int IW = $clog2(NBUF);

	// ==========================================================
	// Pin synchronisers
	logic [10:0] pin_meta;
	logic [10:0] pin_sync;
	logic        rx_done_last;
	logic        tx_done_last;
	logic        rx_active_s;
	logic        rx_done_p;
	logic        tx_done_p;
	logic        ep_s;
	logic [6:0]  rec_s;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_meta <= 11'h000;
			pin_sync <= 11'h000;
			rx_done_last <= 1'b0;
			tx_done_last <= 1'b0;
		end else begin
			pin_meta <= {rx_error_count, error_passive_flag, tx_done, rx_frame_done, rx_active};
			pin_sync <= pin_meta;
			rx_done_last <= pin_sync[1];
			tx_done_last <= pin_sync[2];
		end
	end

	assign rx_active_s = pin_sync[0];
	assign rx_done_p   = pin_sync[1] & ~rx_done_last;
	assign tx_done_p   = pin_sync[2] & ~tx_done_last;
	assign ep_s        = pin_sync[3];
	assign rec_s       = pin_sync[10:4];

	// ==========================================================
	// AHB-Lite slave
	logic       wr_pend;
	logic [7:0] wr_addr;
	logic       addr_phase;
	logic [7:0] rd_addr;
	logic [31:0] next_rdata;

	assign addr_phase = hsel & hready & (htrans == can_txq_pkg::HTRANS_NONSEQ);
	assign rd_addr    = haddr[7:0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend   <= 1'b0;
			wr_addr   <= 8'h00;
			hreadyout <= 1'b1;
			hresp     <= can_txq_pkg::HRESP_OKAY;
		end else begin
			wr_pend   <= addr_phase & hwrite;
			wr_addr   <= haddr[7:0];
			hreadyout <= 1'b1;
			hresp     <= can_txq_pkg::HRESP_OKAY;
		end
	end

	logic wr_ctrl, wr_tx_buffer_add_request, wr_qadd, wr_flags, wr_enable;

	assign wr_ctrl   = wr_pend & (wr_addr == can_txq_pkg::CORE_CONTROL_OFS);
	assign wr_tx_buffer_add_request  = wr_pend & (wr_addr == can_txq_pkg::TX_ADD_REQ_OFS);
	assign wr_qadd   = wr_pend & (wr_addr == can_txq_pkg::QUEUE_ADD_OFS);
	assign wr_flags  = wr_pend & (wr_addr == can_txq_pkg::INT_FLAGS_OFS);
	assign wr_enable = wr_pend & (wr_addr == can_txq_pkg::INT_ENABLE_OFS);

	// ==========================================================
	// Transmit queue
	logic [NBUF-1:0] pending;
	logic [NBUF-1:0] next_pending;
	logic [NBUF-1:0] add_set;
	logic [NBUF-1:0] done_clr;
	logic [IW:0]     free_pick;
	logic [IW:0]     send_pick;
	logic            tx_active;
	logic            tx_start;
	logic            init;

	function automatic logic [IW:0] lowest(input logic [NBUF-1:0] v);
		logic [IW:0] r;
		r = '0;
		for (int i = NBUF - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, IW'(i)};
			end
		end
		return r;
	endfunction

	assign free_pick = lowest(~pending);
	assign send_pick = lowest(pending);
	assign tx_start  = ~tx_active & send_pick[IW] & ~init;

	always_comb begin
		add_set  = '0;
		done_clr = '0;
		if (wr_tx_buffer_add_request) begin
			add_set = hwdata[NBUF-1:0];
		end
		if (wr_qadd && free_pick[IW]) begin
			add_set[free_pick[IW-1:0]] = 1'b1;
		end
		if (tx_active && tx_done_p) begin
			done_clr[tx_buf_sel] = 1'b1;
		end
		next_pending = (pending & ~done_clr) | add_set;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pending <= '0;
		end else begin
			pending <= next_pending;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_active  <= 1'b0;
			tx_buf_sel <= '0;
		end else if (tx_start) begin
			tx_active  <= 1'b1;
			tx_buf_sel <= send_pick[IW-1:0];
		end else if (tx_done_p) begin
			tx_active  <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_req <= 1'b0;
		end else begin
			tx_req <= tx_start | (tx_active & ~tx_done_p);
		end
	end

	// ==========================================================
	// Initialization and clock stop handshake
	can_txq_pkg::stop_state_t stop_state;
	can_txq_pkg::stop_state_t next_stop_state;
	logic clock_stop_request;

	always_comb begin
		next_stop_state = stop_state;
		case (stop_state)
			can_txq_pkg::STOP_RUN: begin
				if (clock_stop_request) begin
					next_stop_state = can_txq_pkg::STOP_WAIT;
				end
			end
			can_txq_pkg::STOP_WAIT: begin
				if (!clock_stop_request) begin
					next_stop_state = can_txq_pkg::STOP_RUN;
				end else if (!rx_active_s && !tx_active) begin
					next_stop_state = can_txq_pkg::STOP_STOPPED;
				end
			end
			can_txq_pkg::STOP_STOPPED: begin
				if (!clock_stop_request) begin
					next_stop_state = can_txq_pkg::STOP_RUN;
				end
			end
			default: next_stop_state = can_txq_pkg::STOP_RUN;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stop_state <= can_txq_pkg::STOP_RUN;
		end else begin
			stop_state <= next_stop_state;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			init <= can_txq_pkg::INIT_RESET;
			clock_stop_request  <= 1'b0;
			init_active <= can_txq_pkg::INIT_RESET;
		end else begin
			init_active <= init;
			if (wr_ctrl) begin
				clock_stop_request <= hwdata[can_txq_pkg::CSR_BIT];
			end
			if (next_stop_state == can_txq_pkg::STOP_STOPPED) begin
				init <= 1'b1;
			end else if (wr_ctrl) begin
				init <= hwdata[can_txq_pkg::INIT_BIT] | (init & hwdata[can_txq_pkg::CSR_BIT]);
			end
		end
	end

	// ==========================================================
	// Interrupt flags
	logic                               init_last;
	logic                               msg_ram_access_fail_flag_armed;
	logic                               msg_ram_access_fail_flag_false;
	logic [can_txq_pkg::NUM_FLAGS-1:0]  flags;
	logic [can_txq_pkg::NUM_FLAGS-1:0]  enable;
	logic [can_txq_pkg::NUM_FLAGS-1:0]  flag_set;
	logic [can_txq_pkg::NUM_FLAGS-1:0]  flag_clr;

	assign msg_ram_access_fail_flag_false = rx_done_p & ep_s & (rec_s == can_txq_pkg::REC_PASSIVE_LIMIT);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			init_last  <= can_txq_pkg::INIT_RESET;
			msg_ram_access_fail_flag_armed <= 1'b0;
		end else begin
			init_last <= init;
			if (init && !init_last && rx_active_s) begin
				msg_ram_access_fail_flag_armed <= 1'b1;
			end else if (!init && rx_done_p) begin
				msg_ram_access_fail_flag_armed <= 1'b0;
			end
		end
	end

	always_comb begin
		flag_set = '0;
		flag_set[can_txq_pkg::MSG_RAM_ACCESS_FAIL_FLAG_BIT] = (msg_ram_access_fail_flag_armed & ~init & rx_done_p) | msg_ram_access_fail_flag_false;
		flag_set[can_txq_pkg::TXC_BIT]  = tx_active & tx_done_p;
		flag_clr = wr_flags ? hwdata[can_txq_pkg::NUM_FLAGS-1:0] : '0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags  <= can_txq_pkg::FLAGS_RESET;
			enable <= can_txq_pkg::ENABLE_RESET;
			irq    <= 1'b0;
		end else begin
			flags <= (flags & ~flag_clr) | flag_set;
			if (wr_enable) begin
				enable <= hwdata[can_txq_pkg::NUM_FLAGS-1:0];
			end
			irq <= |(flags & enable);
		end
	end

	// ==========================================================
	// Read data
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (rd_addr)
			can_txq_pkg::CORE_CONTROL_OFS: begin
				next_rdata[can_txq_pkg::INIT_BIT] = init;
				next_rdata[can_txq_pkg::CSR_BIT]  = clock_stop_request;
				next_rdata[can_txq_pkg::CSA_BIT]  = stop_state == can_txq_pkg::STOP_STOPPED;
			end
			can_txq_pkg::QUEUE_ADD_OFS: begin
				next_rdata[IW-1:0]                 = free_pick[IW-1:0];
				next_rdata[can_txq_pkg::QFULL_BIT] = ~free_pick[IW];
			end
			can_txq_pkg::TX_PENDING_OFS:    next_rdata[NBUF-1:0] = pending;
			can_txq_pkg::INT_FLAGS_OFS:     next_rdata[can_txq_pkg::NUM_FLAGS-1:0] = flags;
			can_txq_pkg::INT_ENABLE_OFS:    next_rdata[can_txq_pkg::NUM_FLAGS-1:0] = enable;
			can_txq_pkg::ERROR_COUNTER_OFS: begin
				next_rdata[can_txq_pkg::REC_WIDTH-1:0] = rec_s;
				next_rdata[can_txq_pkg::EP_BIT]        = ep_s;
			end
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_phase && !hwrite) begin
			hrdata <= next_rdata;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence stop_requested;
		clock_stop_request && stop_state == can_txq_pkg::STOP_WAIT;
	endsequence
	sequence line_quiet;
		!rx_active_s && !tx_active;
	endsequence

	chk_group_add_all: assert property (wr_tx_buffer_add_request |=> ((pending & $past(hwdata[NBUF-1:0])) == $past(hwdata[NBUF-1:0]))) else $error("group add lost a buffer");
	chk_put_lowest_free: assert property (wr_qadd && free_pick[IW] |=> pending[$past(free_pick[IW-1:0])] && ((~$past(pending) & ((NBUF'(1) << $past(free_pick[IW-1:0])) - NBUF'(1))) == '0)) else $error("add did not take lowest free");
	chk_send_lowest: assert property (tx_start |=> tx_buf_sel == $past(send_pick[IW-1:0]) && (($past(pending) & ((NBUF'(1) << tx_buf_sel) - NBUF'(1))) == '0)) else $error("sent buffer was not lowest");
	chk_stop_sets_init: assert property (stop_requested ##0 line_quiet |=> stop_state == can_txq_pkg::STOP_STOPPED ##0 init) else $error("clock stop did not set init");
	chk_stop_waits_line: assert property (stop_requested ##0 rx_active_s |=> stop_state != can_txq_pkg::STOP_STOPPED) else $error("stopped during reception");
	chk_msg_ram_access_fail_flag_after_init: assert property (msg_ram_access_fail_flag_armed && !init && rx_done_p |=> flags[can_txq_pkg::MSG_RAM_ACCESS_FAIL_FLAG_BIT]) else $error("flag missing after init");
	chk_msg_ram_access_fail_flag_passive_127: assert property (rx_done_p && ep_s && rec_s == can_txq_pkg::REC_PASSIVE_LIMIT |=> flags[can_txq_pkg::MSG_RAM_ACCESS_FAIL_FLAG_BIT]) else $error("passive 127 flag missing");
	chk_msg_ram_access_fail_flag_sticky: assert property (flags[can_txq_pkg::MSG_RAM_ACCESS_FAIL_FLAG_BIT] && !flag_clr[can_txq_pkg::MSG_RAM_ACCESS_FAIL_FLAG_BIT] |=> flags[can_txq_pkg::MSG_RAM_ACCESS_FAIL_FLAG_BIT]) else $error("flag dropped uncleared");
	chk_irq_follows_flag: assert property (flags[can_txq_pkg::MSG_RAM_ACCESS_FAIL_FLAG_BIT] && enable[can_txq_pkg::MSG_RAM_ACCESS_FAIL_FLAG_BIT] |=> irq) else $error("interrupt not raised");

endmodule // can_txq_ctrl

// ===== tb/can_engine_model.sv
// Behavioural protocol engine on the transmit side of the queue block
// Assumes tx_req holds until tx_done is seen, and one clock hclk
`timescale 1ns/1ps

module can_engine_model (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic tx_req,
	input  wire logic slow,
	output logic      tx_done
);
	// ==========================================================
	// Frame time, prompt or slow; done drops once the request falls
	logic [3:0] cnt;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt     <= 4'h0;
			tx_done <= 1'b0;
		end else if (!tx_req) begin
			cnt     <= 4'h0;
			tx_done <= 1'b0;
		end else if (!tx_done) begin
			cnt     <= cnt + 4'h1;
			tx_done <= (cnt == (slow ? 4'hc : 4'h4));
		end
	end
endmodule // can_engine_model

// ===== tb/can_txq_ctrl_tb_top.sv
// Self-checking bench for the transmit queue and initialization control
// Assumes zero wait state AHB-Lite slave and the engine model as far side
`timescale 1ns/1ps

module can_txq_ctrl_tb_top;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        hready;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        rx_active = 1'b0;
	logic        rx_frame_done = 1'b0;
	logic        error_passive_flag = 1'b0;
	logic [6:0]  rx_error_count = 7'h0;
	logic        slow = 1'b0;
	logic        tx_done;
	logic        tx_req;
	logic [2:0]  tx_buf_sel;
	logic        init_active;
	logic        irq;
	logic        tx_req_q = 1'b0;
	logic [2:0]  sent_q[$];
	logic [31:0] rd;
	int          num_errors = 0;
	int          checks = 0;

	assign hready = hreadyout;
	always #4 hclk = ~hclk;

	can_txq_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_active(rx_active),
		.rx_frame_done(rx_frame_done), .error_passive_flag(error_passive_flag),
		.rx_error_count(rx_error_count), .tx_done(tx_done), .tx_req(tx_req),
		.tx_buf_sel(tx_buf_sel), .init_active(init_active), .irq(irq));

	can_engine_model engine_u (.hclk(hclk), .hresetn(hresetn), .tx_req(tx_req), .slow(slow),
		.tx_done(tx_done));

	// ==========================================================
	// Record the buffer of every started transmission
	always @(posedge hclk) begin
		tx_req_q <= tx_req;
		if (tx_req && !tx_req_q) sent_q.push_back(tx_buf_sel);
	end

	// ==========================================================
	// Bus and comparison helpers
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] ofs, input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= {24'h0, ofs};
		htrans <= can_txq_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
		xfer(1'b1, ofs, d);
	endtask

	task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] exp, input string name);
		xfer(1'b0, ofs, 32'h0);
		check(name, rd, exp);
	endtask

	task automatic wait_bits(input logic [7:0] ofs, input logic [31:0] mask,
		input logic [31:0] val);
		for (int i = 0; i < 100; i++) begin
			xfer(1'b0, ofs, 32'h0);
			if ((rd & mask) == val) break;
		end
	endtask

	task automatic rx_frame();
		rx_active <= 1'b1;
		repeat (6) @(posedge hclk);
		rx_frame_done <= 1'b1;
		repeat (3) @(posedge hclk);
		rx_active <= 1'b0;
		rx_frame_done <= 1'b0;
		repeat (8) @(posedge hclk);
	endtask

	// ==========================================================
	// Scenarios
	task automatic test_reset();
		rd_chk(can_txq_pkg::CORE_CONTROL_OFS, 32'h1, "core");
		rd_chk(can_txq_pkg::INT_FLAGS_OFS, 32'h0, "flags");
		wr(8'h1c, 32'hff);
		rd_chk(8'h1c, 32'h0, "unmapped");
		rd_chk(can_txq_pkg::CORE_CONTROL_OFS, 32'h1, "core");
	endtask

	task automatic test_group();
		logic [2:0] exp_q[4] = '{3'h0, 3'h2, 3'h5, 3'h7};
		sent_q.delete();
		slow <= 1'b1;
		wr(can_txq_pkg::INT_ENABLE_OFS, 32'h3);
		wr(can_txq_pkg::TX_ADD_REQ_OFS, 32'ha5);
		check("okay", {30'h0, hreadyout, hresp}, 32'h2);
		rd_chk(can_txq_pkg::TX_PENDING_OFS, 32'ha5, "pending");
		check("started", sent_q.size(), 32'h0);
		wr(can_txq_pkg::CORE_CONTROL_OFS, 32'h0);
		wait_bits(can_txq_pkg::TX_PENDING_OFS, 32'hff, 32'h0);
		check("count", sent_q.size(), 32'h4);
		for (int i = 0; i < 4; i++) check("order", {29'h0, sent_q[i]}, {29'h0, exp_q[i]});
		rd_chk(can_txq_pkg::INT_FLAGS_OFS, 32'h2, "flags");
		check("irq", {31'h0, irq}, 32'h1);
		wr(can_txq_pkg::INT_FLAGS_OFS, 32'h2);
		repeat (2) @(posedge hclk);
		check("irq", {31'h0, irq}, 32'h0);
	endtask

	task automatic test_queue();
		sent_q.delete();
		slow <= 1'b0;
		wr(can_txq_pkg::CORE_CONTROL_OFS, 32'h1);
		rd_chk(can_txq_pkg::QUEUE_ADD_OFS, 32'h0, "pointer");
		wr(can_txq_pkg::TX_ADD_REQ_OFS, 32'h5);
		rd_chk(can_txq_pkg::QUEUE_ADD_OFS, 32'h1, "pointer");
		wr(can_txq_pkg::QUEUE_ADD_OFS, 32'h0);
		rd_chk(can_txq_pkg::QUEUE_ADD_OFS, 32'h3, "pointer");
		repeat (6) wr(can_txq_pkg::QUEUE_ADD_OFS, 32'h0);
		rd_chk(can_txq_pkg::TX_PENDING_OFS, 32'hff, "pending");
		xfer(1'b0, can_txq_pkg::QUEUE_ADD_OFS, 32'h0);
		check("full", rd & 32'h100, 32'h100);
		wr(can_txq_pkg::CORE_CONTROL_OFS, 32'h0);
		wait_bits(can_txq_pkg::TX_PENDING_OFS, 32'hff, 32'h0);
		for (int i = 0; i < 8; i++) check("order", {29'h0, sent_q[i]}, i);
		wr(can_txq_pkg::INT_FLAGS_OFS, 32'h2);
	endtask

	task automatic test_reuse();
		sent_q.delete();
		for (int i = 0; i < 3; i++) begin
			wr(can_txq_pkg::TX_ADD_REQ_OFS, 32'h8);
			wait_bits(can_txq_pkg::TX_PENDING_OFS, 32'h8, 32'h0);
		end
		check("reuse", sent_q.size(), 32'h3);
		for (int i = 0; i < 3; i++) check("fifo", {29'h0, sent_q[i]}, 32'h3);
		wr(can_txq_pkg::INT_FLAGS_OFS, 32'h2);
	endtask

	task automatic test_stop();
		rx_active <= 1'b1;
		repeat (3) @(posedge hclk);
		wr(can_txq_pkg::CORE_CONTROL_OFS, 32'h2);
		repeat (4) @(posedge hclk);
		rd_chk(can_txq_pkg::CORE_CONTROL_OFS, 32'h2, "core");
		rx_active <= 1'b0;
		wait_bits(can_txq_pkg::CORE_CONTROL_OFS, 32'h4, 32'h4);
		rd_chk(can_txq_pkg::CORE_CONTROL_OFS, 32'h7, "core");
		check("init", {31'h0, init_active}, 32'h1);
		wr(can_txq_pkg::CORE_CONTROL_OFS, 32'h2);
		rd_chk(can_txq_pkg::CORE_CONTROL_OFS, 32'h7, "core");
		wr(can_txq_pkg::CORE_CONTROL_OFS, 32'h1);
		wr(can_txq_pkg::CORE_CONTROL_OFS, 32'h0);
		wait_bits(can_txq_pkg::CORE_CONTROL_OFS, 32'h7, 32'h0);
		rd_chk(can_txq_pkg::CORE_CONTROL_OFS, 32'h0, "core");
	endtask

	task automatic test_init_rx();
		rx_active <= 1'b1;
		repeat (4) @(posedge hclk);
		wr(can_txq_pkg::CORE_CONTROL_OFS, 32'h1);
		rx_active <= 1'b0;
		wr(can_txq_pkg::CORE_CONTROL_OFS, 32'h0);
		rd_chk(can_txq_pkg::INT_FLAGS_OFS, 32'h0, "flags");
		rx_frame();
		rd_chk(can_txq_pkg::INT_FLAGS_OFS, 32'h1, "flags");
		check("irq", {31'h0, irq}, 32'h1);
		repeat (20) @(posedge hclk);
		rd_chk(can_txq_pkg::INT_FLAGS_OFS, 32'h1, "flags");
		wr(can_txq_pkg::INT_FLAGS_OFS, 32'h1);
		repeat (2) @(posedge hclk);
		check("irq", {31'h0, irq}, 32'h0);
		rx_frame();
		rd_chk(can_txq_pkg::INT_FLAGS_OFS, 32'h0, "flags");
	endtask

	task automatic test_passive();
		error_passive_flag <= 1'b1;
		rx_error_count <= 7'h7e;
		repeat (4) @(posedge hclk);
		rd_chk(can_txq_pkg::ERROR_COUNTER_OFS, 32'hfe, "errcount");
		rx_frame();
		rd_chk(can_txq_pkg::INT_FLAGS_OFS, 32'h0, "flags");
		rx_error_count <= 7'h7f;
		repeat (4) @(posedge hclk);
		rd_chk(can_txq_pkg::ERROR_COUNTER_OFS, 32'hff, "errcount");
		rx_frame();
		rd_chk(can_txq_pkg::INT_FLAGS_OFS, 32'h1, "flags");
		wr(can_txq_pkg::INT_FLAGS_OFS, 32'h1);
		rd_chk(can_txq_pkg::INT_FLAGS_OFS, 32'h0, "flags");
	endtask

	// ==========================================================
	// Verdict and run control
	task automatic finish_test();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge hclk);
		num_errors++;
		finish_test();
	end

	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		test_reset();
		test_group();
		test_queue();
		test_reuse();
		test_stop();
		test_init_rx();
		test_passive();
		finish_test();
	end
endmodule // can_txq_ctrl_tb_top
